// [bench/tb_ext_master_burst_auto_ack.sv]
/*
  Self-checking bench: both ends joined by the link, registers driven as an
  AHB-Lite master, burst timing and data compared with a bench model.
  Assumes the design files and the constants header are compiled first.
*/
`timescale 1ns/100ps

//////////////////////////////////////////////////////////////////////////////
module tb_ext_master_burst_auto_ack;
  logic         mclk_in, rst_b_in, hsel, hwrite, hready, hresp;
  logic [1:0]   htrans, cmd_width, cmd_port, wd;
  logic [2:0]   hsize;
  logic [31:0]  haddr, hwdata, hrdata, rv;
  logic         cmd_start, cmd_read, cmd_allow, busy, done, refused;
  logic [27:0]  cmd_addr;
  logic [127:0] cmd_wline, rd_line;
  logic [7:0]   pat;
  int           bad_count, samples_checked, seed, acks, cur_pb;
  int           cyc = 0;
  int           wt[8] = '{0, 0, 3, 3, 3, 2, 1, 0};
  int           pt[8] = '{1, 2, 0, 2, 1, 1, 1, 0};
  byte unsigned wq[$];

  xb_link_if xb_link_if_i ();
  // Bench memory: each byte is its own address low byte mixed with a pattern
  assign xb_link_if_i.slv_data = {xb_link_if_i.addr[7:0] ^ pat,
                                  (xb_link_if_i.addr[7:0] + 8'h01) ^ pat,
                                  (xb_link_if_i.addr[7:0] + 8'h02) ^ pat,
                                  (xb_link_if_i.addr[7:0] + 8'h03) ^ pat};
  // Memory answers reads only; the master mux wins on writes anyway
  assign xb_link_if_i.slv_data_oe = xb_link_if_i.rw;

  xb_dev_term xb_dev_term_i (
    .mclk_in       (mclk_in),
    .rst_b_in      (rst_b_in),
    .link          (xb_link_if_i),
    .hsel_in       (hsel),
    .haddr_in      (haddr),
    .htrans_in     (htrans),
    .hwrite_in     (hwrite),
    .hsize_in      (hsize),
    .hwdata_in     (hwdata),
    .hready_in     (hready),
    .hrdata_out    (hrdata),
    .hreadyout_out (hready),
    .hresp_out     (hresp)
  );

  xb_ext_master xb_ext_master_i (
    .mclk_in            (mclk_in),
    .rst_b_in           (rst_b_in),
    .link               (xb_link_if_i),
    .cmd_start_in       (cmd_start),
    .cmd_addr_in        (cmd_addr),
    .cmd_read_in        (cmd_read),
    .cmd_width_in       (cmd_width),
    .cmd_port_in        (cmd_port),
    .cmd_burst_allow_in (cmd_allow),
    .cmd_wline_in       (cmd_wline),
    .busy_out           (busy),
    .done_out           (done),
    .refused_out        (refused),
    .rd_line_out        (rd_line)
  );

  xb_link_checker xb_link_checker_i (
    .mclk_in         (mclk_in),
    .rst_b_in        (rst_b_in),
    .addr            (xb_link_if_i.addr),
    .rw              (xb_link_if_i.rw),
    .xfer_begin_n    (xb_link_if_i.xfer_begin_n),
    .ack_oe          (xb_link_if_i.ack_oe),
    .xfer_done_ack_n (xb_link_if_i.xfer_done_ack_n),
    .mst_data_oe     (xb_link_if_i.mst_data_oe)
  );

  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end

  // Beat counter and write-data capture, sampled before the edge updates
  always @(posedge mclk_in) begin
    if (!xb_link_if_i.xfer_begin_n) begin
      acks = 0;
    end else if (!xb_link_if_i.xfer_done_ack_n) begin
      acks++;
      if (!xb_link_if_i.rw) begin
        for (int k = 0; k < cur_pb; k++) wq.push_back(xb_link_if_i.data[31-8*k -: 8]);
      end
    end
  end

  // Ceiling well above the longest scenario set
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      $display("[ERR] timeout expected 0 seen %0d", cyc);
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] s);
    samples_checked++;
    if (e !== s) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic ahb_write(input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= 1'b1;
    hsize  <= 3'h2;
    htrans <= 2'h2;
    do @(posedge mclk_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk_in); while (hready !== 1'b1);
  endtask

  task automatic ahb_read(input logic [7:0] a, output logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= 1'b0;
    hsize  <= 3'h2;
    htrans <= 2'h2;
    do @(posedge mclk_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    do @(posedge mclk_in); while (hready !== 1'b1);
    d = hrdata;
    chk("hresp", 0, hresp);
  endtask

  task automatic run_burst(input logic rd, input logic [1:0] w_c, input logic [1:0] prt,
                           input int w);
    int           nby, nb, n;
    logic [127:0] e, wl;
    logic [27:0]  a;
    nby = (w_c == 2'h1) ? 1 : (w_c == 2'h2) ? 2 : (w_c == 2'h3) ? 16 : 4;
    cur_pb = (prt == 2'h1) ? 1 : (prt == 2'h2) ? 2 : 4;
    nb = nby / cur_pb;
    ahb_write(8'h00, {24'h000000, prt, 4'(w), 2'h3});
    ahb_read(8'h00, rv);
    chk("def_ctrl", {24'h000000, prt, 4'(w), 2'h3}, rv);
    rv = $random(seed);
    a  = {8'h00, rv[19:0]};
    wl = {$random(seed), $random(seed), $random(seed), $random(seed)};
    wq.delete();
    pat       <= rv[31:24];
    cmd_addr  <= a;
    cmd_read  <= rd;
    cmd_width <= w_c;
    cmd_port  <= prt;
    cmd_allow <= 1'b1;
    cmd_wline <= wl;
    cmd_start <= 1'b1;
    @(posedge mclk_in);
    cmd_start <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (done !== 1'b1 && n < 400);
    chk("burst_cycles", 3 + nb * (w + 1), n);
    chk("beats", nb, acks);
    e = '0;
    if (rd) begin
      for (int k = 0; k < nby; k++) e = {e[119:0], 8'(a[7:0] + k) ^ pat};
      chk("rd_line", e, rd_line);
    end else begin
      chk("wr_bytes", nby, wq.size());
      for (int k = 0; k < nby && k < wq.size(); k++) e = {e[119:0], wq[k]};
      chk("wr_data", wl >> (128 - 8 * nby), e);
    end
    repeat (2) @(posedge mclk_in);
    chk("busy_after", 0, busy);
    chk("ack_released", 0, xb_link_if_i.ack_oe);
    ahb_read(8'h08, rv);
    chk("status", {rd, 4'h0}, {rv[12], 1'b0, rv[10:8]});
  endtask

  task automatic run_refused(input logic allow);
    cmd_width <= allow ? 2'h0 : 2'h3;
    cmd_port  <= allow ? 2'h0 : 2'h1;
    cmd_allow <= allow;
    cmd_start <= 1'b1;
    @(posedge mclk_in);
    cmd_start <= 1'b0;
    @(posedge mclk_in);
    chk("refused", 1, refused);
    chk("refused_busy", 0, busy);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    seed = 26;
    bad_count = 0;
    samples_checked = 0;
    acks = 0;
    cur_pb = 4;
    rst_b_in = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    cmd_start = 1'b0;
    cmd_addr = 28'h000_0000;
    cmd_read = 1'b1;
    cmd_width = 2'h0;
    cmd_port = 2'h0;
    cmd_allow = 1'b0;
    cmd_wline = '0;
    pat = 8'h00;
    repeat (20) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    @(posedge mclk_in);
    chk("rst_ack_oe", 0, xb_link_if_i.ack_oe);
    chk("rst_begin", 1, xb_link_if_i.xfer_begin_n);
    chk("rst_busy", 0, busy);
    // Select space parked away from the burst addresses
    ahb_write(8'h04, 32'hFF00_0000);
    for (int i = 0; i < 8; i++) begin
      rv = $random(seed);
      wd = (pt[i] == 0) ? 2'h3 : (pt[i] == 2) ? (rv[0] ? 2'h0 : 2'h3) :
           (rv[0] ? 2'h0 : (rv[1] ? 2'h2 : 2'h3));
      run_burst(1'(i % 2), wd, 2'(pt[i]), wt[i]);
    end
    run_refused(1'b1);
    run_refused(1'b0);
    // Second reset in mid-run clears the control set
    rst_b_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    @(posedge mclk_in);
    chk("rst2_ack_oe", 0, xb_link_if_i.ack_oe);
    chk("rst2_busy", 0, busy);
    ahb_read(8'h00, rv);
    chk("rst2_def_ctrl", 0, rv);
    test_done();
  end
endmodule // tb_ext_master_burst_auto_ack

// [bench/xb_link_checker.sv]
/*
  Concurrent checks on the shared burst link between the two design ends.
  Assumes one clock domain and that only bursts of two or more beats run.
*/
`timescale 1ns/100ps

//////////////////////////////////////////////////////////////////////////////
module xb_link_checker (
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  input  wire logic [27:0] addr,
  input  wire logic        rw,
  input  wire logic        xfer_begin_n,
  input  wire logic        ack_oe,
  input  wire logic        xfer_done_ack_n,
  input  wire logic        mst_data_oe
);
  logic [4:0] beat_cnt_reg;
  logic [4:0] beat_cnt_next;

  // Saturates so that a runaway burst still trips the beat limit
  assign beat_cnt_next = !xfer_begin_n ? 5'h00 :
                         (!xfer_done_ack_n && beat_cnt_reg != 5'h1F) ? beat_cnt_reg + 5'h01 :
                         beat_cnt_reg;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      beat_cnt_reg <= 5'h00;
    end else begin
      beat_cnt_reg <= beat_cnt_next;
    end
  end

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  //////////////////////////////////////////////////////////////////////////////
  a_decode_gap: assert property (!xfer_begin_n |=> xfer_done_ack_n && !ack_oe)
    else $error("acknowledge seen in the decode clock");
  a_begin_pulse: assert property (!xfer_begin_n |=> xfer_begin_n)
    else $error("start strobe held past its first clock");
  a_ack_launch: assert property ($rose(ack_oe) |-> !$past(xfer_begin_n, 2))
    else $error("acknowledge driven at the wrong distance from start");
  a_write_data: assert property (!xfer_begin_n |=> mst_data_oe == !$past(rw))
    else $error("write data not placed in the second clock");
  a_addr_hold: assert property ($changed(addr) && ack_oe |-> !$past(xfer_done_ack_n))
    else $error("address moved without an acknowledge");
  a_ack_bound: assert property (ack_oe && xfer_done_ack_n |-> ##[0:16] (!xfer_done_ack_n || !ack_oe))
    else $error("acknowledge late beyond the widest wait count");
  a_ack_release: assert property ($fell(ack_oe) |-> $past(xfer_done_ack_n) && !$past(xfer_done_ack_n, 2))
    else $error("acknowledge released without one negated clock");
  a_beat_range: assert property ($fell(ack_oe) |-> beat_cnt_reg >= 5'h02 && beat_cnt_reg <= 5'h10)
    else $error("burst beat count outside two to sixteen");
  a_data_release: assert property ($fell(mst_data_oe) |-> !$past(xfer_done_ack_n))
    else $error("write data released away from the final beat");
endmodule // xb_link_checker

// [rtl/xb_burst_cfg.svh]
/*
  Constants for the external-master burst acknowledge link: register offsets,
  field positions, reset values and line size.
  Assumes it is included by bare name by the package and the design modules.
*/
`ifndef XB_BURST_CFG_SVH
`define XB_BURST_CFG_SVH

`define XB_DEF_OFS     8'h00
`define XB_SEL_OFS     8'h04
`define XB_STAT_OFS    8'h08

`define XB_AAE_BIT     0
`define XB_BURST_ALLOW_BIT    1
`define XB_WS_LSB      2
`define XB_WS_MSB      5
`define XB_PS_LSB      6
`define XB_PS_MSB      7
`define XB_BASE_LSB    24
`define XB_BASE_MSB    31

`define XB_DEF_RST     32'h0000_0000
`define XB_SEL_RST     32'h0000_0000

`define XB_LINE_BITS   128

`endif

// [rtl/xb_dev_term.sv]
/*
  Device end: registers an external master's burst request, decodes the space,
  and drives the automatic acknowledge beat by beat, then releases it.
  Control registers are reached over an AHB-Lite slave port.
  Assumes the master shares mclk_in and keeps to the burst protocol.
*/
`timescale 1ns/100ps
`include "xb_burst_cfg.svh"

// Behaviour
// - Spend one decode clock before wait counting
// - Master advances default-space address after acknowledge
// - Master never bursts where burst disallowed
// - Burst is two to sixteen acknowledged beats
// - Read start: address, read, width, begin
// - Write: begin negated, first data clock two
// - Register request at clock two, then decode
// - Auto-ack enabled: pick wait count clock two
// - Master negates begin, samples acknowledge, clock two
// - Zero wait: acknowledge asserted at clock three
// - Nonzero wait drives negated, zero asserted
// - Master holds beat while acknowledge negated
// - Byte port: top lane, address plus one
// - Halfword port: address plus two, upper lanes
// - Zero wait holds acknowledge across beats
// - Negate after final beat, then release
// - Data bus released after final beat
// - Default space acknowledges after programmed waits
// - Device never drives the address bus
module xb_dev_term (
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  xb_link_if.dev           link,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  xb_pkg::xb_dstate_type state_reg, state_next;
  logic [31:0] def_ctrl_reg;
  logic [31:0] sel_ctrl_reg;
  logic [27:0] addr_reg;
  logic        rw_reg;
  logic [1:0]  width_reg;
  logic [3:0]  left_reg, left_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic [3:0]  ws_reg, ws_next;
  logic        ack_n_reg, ack_n_next;
  logic        ack_oe_reg, ack_oe_next;
  logic        ph_valid_reg;
  logic        ph_write_reg;
  logic [7:0]  ph_addr_reg;
  logic [31:0] hrdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the registered request

  wire         sel_hit  = addr_reg[27:20] == sel_ctrl_reg[`XB_BASE_MSB:`XB_BASE_LSB];
  wire  [31:0] ctl      = sel_hit ? sel_ctrl_reg : def_ctrl_reg;
  wire         auto_en  = ctl[`XB_AAE_BIT];
  wire  [3:0]  ws_sel   = ctl[`XB_WS_MSB:`XB_WS_LSB];
  wire  [1:0]  ps_sel   = ctl[`XB_PS_MSB:`XB_PS_LSB];
  wire  [4:0]  nbeats   = xb_pkg::xb_beats(width_reg, ps_sel);
  wire         beat_end = left_reg == 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge sequencer

  always_comb begin
    state_next  = state_reg;
    left_next   = left_reg;
    cnt_next    = cnt_reg;
    ws_next     = ws_reg;
    ack_n_next  = ack_n_reg;
    ack_oe_next = ack_oe_reg;
    case (state_reg)
      xb_pkg::XB_D_IDLE: begin
        if (!link.xfer_begin_n) begin
          state_next = xb_pkg::XB_D_DECODE;
        end
      end
      xb_pkg::XB_D_DECODE: begin
        if (auto_en) begin
          ws_next     = ws_sel;
          left_next   = 4'(nbeats - 5'h01);
          ack_oe_next = 1'b1;
          if (ws_sel == 4'h0) begin
            ack_n_next = 1'b0;
            state_next = xb_pkg::XB_D_ACK;
          end else begin
            ack_n_next = 1'b1;
            cnt_next   = ws_sel;
            state_next = xb_pkg::XB_D_WAIT;
          end
        end else begin
          // Another agent terminates; stay off the line
          state_next = xb_pkg::XB_D_IDLE;
        end
      end
      xb_pkg::XB_D_WAIT: begin
        if (cnt_reg == 4'h1) begin
          ack_n_next = 1'b0;
          state_next = xb_pkg::XB_D_ACK;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      xb_pkg::XB_D_ACK: begin
        if (beat_end) begin
          ack_n_next = 1'b1;
          state_next = xb_pkg::XB_D_NEGATE;
        end else begin
          left_next = left_reg - 4'h1;
          if (ws_reg == 4'h0) begin
            ack_n_next = 1'b0;
          end else begin
            ack_n_next = 1'b1;
            cnt_next   = ws_reg;
            state_next = xb_pkg::XB_D_WAIT;
          end
        end
      end
      xb_pkg::XB_D_NEGATE: begin
        ack_oe_next = 1'b0;
        state_next  = xb_pkg::XB_D_IDLE;
      end
      default: begin
        ack_n_next  = 1'b1;
        ack_oe_next = 1'b0;
        state_next  = xb_pkg::XB_D_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg  <= xb_pkg::XB_D_IDLE;
      left_reg   <= 4'h0;
      cnt_reg    <= 4'h0;
      ws_reg     <= 4'h0;
      ack_n_reg  <= 1'b1;
      ack_oe_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      left_reg   <= left_next;
      cnt_reg    <= cnt_next;
      ws_reg     <= ws_next;
      ack_n_reg  <= ack_n_next;
      ack_oe_reg <= ack_oe_next;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      addr_reg  <= 28'h000_0000;
      rw_reg    <= 1'b1;
      width_reg <= 2'h0;
    end else if (state_reg == xb_pkg::XB_D_IDLE && !link.xfer_begin_n) begin
      addr_reg  <= link.addr;
      rw_reg    <= link.rw;
      width_reg <= link.width_code;
    end
  end

  // address is only ever sampled here, never driven
  assign link.ack_n_drv = ack_n_reg;
  assign link.ack_oe    = ack_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite register slave, zero wait states

  wire        ahb_take = hsel_in && hready_in && htrans_in[1];
  wire [7:0]  rd_ofs   = haddr_in[7:0];
  wire [31:0] status   = {16'h0000, 3'h0, rw_reg, 1'b0, state_reg, left_reg, cnt_reg};
  wire [31:0] rd_mux   = (rd_ofs == `XB_DEF_OFS)  ? def_ctrl_reg :
                         (rd_ofs == `XB_SEL_OFS)  ? sel_ctrl_reg :
                         (rd_ofs == `XB_STAT_OFS) ? status : 32'h0000_0000;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg  <= 8'h00;
      hrdata_reg   <= 32'h0000_0000;
    end else begin
      ph_valid_reg <= ahb_take;
      ph_write_reg <= hwrite_in;
      ph_addr_reg  <= rd_ofs;
      // Read data fetched at the address phase so the data phase needs no wait
      if (ahb_take && !hwrite_in) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  // Changes land between bursts only in effect: the wait count is latched
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      def_ctrl_reg <= `XB_DEF_RST;
      sel_ctrl_reg <= `XB_SEL_RST;
    end else if (ph_valid_reg && ph_write_reg) begin
      if (ph_addr_reg == `XB_DEF_OFS) begin
        def_ctrl_reg <= hwdata_in;
      end
      if (ph_addr_reg == `XB_SEL_OFS) begin
        sel_ctrl_reg <= hwdata_in;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end
  end

  assign hrdata_out = hrdata_reg;

endmodule // xb_dev_term

// [rtl/xb_ext_master.sv]
/*
  External master end: runs one burst read or write per command, steps the
  address by the port width and packs or unpacks the line in the top lanes.
  Assumes the acknowledging device shares mclk_in.
*/
`timescale 1ns/100ps
`include "xb_burst_cfg.svh"

module xb_ext_master (
  input  wire logic                     mclk_in,
  input  wire logic                     rst_b_in,
  xb_link_if.mst                        link,
  input  wire logic                     cmd_start_in,
  input  wire logic [27:0]              cmd_addr_in,
  input  wire logic                     cmd_read_in,
  input  wire logic [1:0]               cmd_width_in,
  input  wire logic [1:0]               cmd_port_in,
  input  wire logic                     cmd_burst_allow_in,
  input  wire logic [`XB_LINE_BITS-1:0] cmd_wline_in,
  output logic                          busy_out,
  output logic                          done_out,
  output logic                          refused_out,
  output logic [`XB_LINE_BITS-1:0]      rd_line_out
);

  localparam int LB = `XB_LINE_BITS;

  ////////////////////////////////////////////////////////////////////////////
  // State

  xb_pkg::xb_mstate_type state_reg;
  logic [27:0]   addr_reg;
  logic          rw_reg;
  logic [1:0]    width_reg;
  logic [1:0]    port_reg;
  logic          begin_n_reg;
  logic          data_oe_reg;
  logic [3:0]    left_reg;
  logic [LB-1:0] wsh_reg;
  logic [LB-1:0] rsh_reg;

  wire [4:0]  cmd_beats = xb_pkg::xb_beats(cmd_width_in, cmd_port_in);
  wire [4:0]  step      = xb_pkg::xb_port_bytes(port_reg);
  wire        ack       = !link.xfer_done_ack_n;
  wire        cmd_ok    = cmd_burst_allow_in && cmd_beats >= 5'h02;

  logic [LB-1:0] wsh_next;
  logic [LB-1:0] rsh_next;

  always_comb begin
    case (port_reg)
      2'h1: begin
        wsh_next = {wsh_reg[LB-9:0], 8'h00};
        rsh_next = {rsh_reg[LB-9:0], link.data[31:24]};
      end
      2'h2: begin
        wsh_next = {wsh_reg[LB-17:0], 16'h0000};
        rsh_next = {rsh_reg[LB-17:0], link.data[31:16]};
      end
      default: begin
        wsh_next = {wsh_reg[LB-33:0], 32'h0000_0000};
        rsh_next = {rsh_reg[LB-33:0], link.data};
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst sequencer

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg   <= xb_pkg::XB_M_IDLE;
      addr_reg    <= 28'h000_0000;
      rw_reg      <= 1'b1;
      width_reg   <= 2'h0;
      port_reg    <= 2'h0;
      begin_n_reg <= 1'b1;
      data_oe_reg <= 1'b0;
      left_reg    <= 4'h0;
      wsh_reg     <= '0;
      rsh_reg     <= '0;
      busy_out    <= 1'b0;
      done_out    <= 1'b0;
      refused_out <= 1'b0;
      rd_line_out <= '0;
    end else begin
      done_out    <= 1'b0;
      refused_out <= 1'b0;
      case (state_reg)
        xb_pkg::XB_M_IDLE: begin
          if (cmd_start_in && cmd_ok) begin
            addr_reg    <= cmd_addr_in;
            rw_reg      <= cmd_read_in;
            width_reg   <= cmd_width_in;
            port_reg    <= cmd_port_in;
            begin_n_reg <= 1'b0;
            left_reg    <= 4'(cmd_beats - 5'h01);
            wsh_reg     <= cmd_wline_in;
            rsh_reg     <= '0;
            busy_out    <= 1'b1;
            state_reg   <= xb_pkg::XB_M_START;
          end else if (cmd_start_in) begin
            refused_out <= 1'b1;
          end
        end
        xb_pkg::XB_M_START: begin
          begin_n_reg <= 1'b1;
          data_oe_reg <= !rw_reg;
          state_reg   <= xb_pkg::XB_M_BEAT;
        end
        xb_pkg::XB_M_BEAT: begin
          if (ack) begin
            rsh_reg <= rsh_next;
            wsh_reg <= wsh_next;
            if (left_reg == 4'h0) begin
              data_oe_reg <= 1'b0;
              rd_line_out <= rsh_next;
              done_out    <= 1'b1;
              state_reg   <= xb_pkg::XB_M_GAP;
            end else begin
              left_reg <= left_reg - 4'h1;
              addr_reg <= addr_reg + {23'h000000, step};
            end
          end
        end
        xb_pkg::XB_M_GAP: begin
          // Lets the device negate and release before a new request
          busy_out  <= 1'b0;
          state_reg <= xb_pkg::XB_M_IDLE;
        end
        default: begin
          state_reg <= xb_pkg::XB_M_IDLE;
        end
      endcase
    end
  end

  assign link.addr         = addr_reg;
  assign link.rw           = rw_reg;
  assign link.width_code   = width_reg;
  assign link.xfer_begin_n = begin_n_reg;
  assign link.mst_data     = wsh_reg[LB-1:LB-32];
  assign link.mst_data_oe  = data_oe_reg;

endmodule // xb_ext_master

// [rtl/xb_link_if.sv]
/*
  Shared bus between the external master and the acknowledging device.
  Assumes a pull-up on the acknowledge and the data bus; the slave memory
  side (slv_data, slv_data_oe) is driven from outside both ends.
*/
`timescale 1ns/100ps

interface xb_link_if;
  logic [27:0] addr;
  logic        rw;
  logic [1:0]  width_code;
  logic        xfer_begin_n;
  logic        ack_n_drv;
  logic        ack_oe;
  logic        xfer_done_ack_n;
  logic [31:0] mst_data;
  logic        mst_data_oe;
  logic [31:0] slv_data;
  logic        slv_data_oe;
  logic [31:0] data;

  // Pull-ups resolve undriven lines high
  assign xfer_done_ack_n = ack_oe ? ack_n_drv : 1'b1;
  assign data = mst_data_oe ? mst_data : (slv_data_oe ? slv_data : 32'hFFFF_FFFF);

  modport dev (
    input  addr, rw, width_code, xfer_begin_n,
    output ack_n_drv, ack_oe
  );

  modport mst (
    output addr, rw, width_code, xfer_begin_n, mst_data, mst_data_oe,
    input  xfer_done_ack_n, data
  );
endinterface

// [rtl/xb_pkg.sv]
/*
  Types and shared decoding for the burst acknowledge link.
  Assumes the constants header is on the include path.
*/
`include "xb_burst_cfg.svh"

package xb_pkg;

  typedef enum logic [1:0] {
    XB_W_LONG = 2'h0,
    XB_W_BYTE = 2'h1,
    XB_W_WORD = 2'h2,
    XB_W_LINE = 2'h3
  } xb_width_type;

  // Port size codes held in the space control registers
  typedef enum logic [1:0] {
    XB_P_32 = 2'h0,
    XB_P_8  = 2'h1,
    XB_P_16 = 2'h2
  } xb_port_type;

  typedef enum logic [2:0] {
    XB_D_IDLE   = 3'h0,
    XB_D_DECODE = 3'h1,
    XB_D_WAIT   = 3'h2,
    XB_D_ACK    = 3'h3,
    XB_D_NEGATE = 3'h4
  } xb_dstate_type;

  typedef enum logic [1:0] {
    XB_M_IDLE  = 2'h0,
    XB_M_START = 2'h1,
    XB_M_BEAT  = 2'h2,
    XB_M_GAP   = 2'h3
  } xb_mstate_type;

  function automatic logic [4:0] xb_bytes(input logic [1:0] w);
    case (w)
      2'h1:    xb_bytes = 5'h01;
      2'h2:    xb_bytes = 5'h02;
      2'h3:    xb_bytes = 5'h10;
      default: xb_bytes = 5'h04;
    endcase
  endfunction

  function automatic logic [4:0] xb_port_bytes(input logic [1:0] p);
    case (p)
      2'h1:    xb_port_bytes = 5'h01;
      2'h2:    xb_port_bytes = 5'h02;
      default: xb_port_bytes = 5'h04;
    endcase
  endfunction

  // Beats in a transfer: transfer bytes over port bytes, never below one
  function automatic logic [4:0] xb_beats(input logic [1:0] w, input logic [1:0] p);
    logic [4:0] b;
    b = xb_bytes(w);
    case (p)
      2'h1:    xb_beats = b;
      2'h2:    xb_beats = (b > 5'h01) ? (b >> 1) : 5'h01;
      default: xb_beats = (b > 5'h03) ? (b >> 2) : 5'h01;
    endcase
  endfunction

endpackage
